// *** gpio_pkg.sv ***
// constants, offsets and reset values for the pulse command port
package gpio_pkg;
  localparam int CHANNELS = 24;
  localparam int PULSE_CHANNELS = 8;
  localparam int COUNT_WIDTH = 20;
  localparam int IRQ_LOW = 16;
  localparam int IRQ_COUNT = 8;
  localparam int IRQ_LINE_BASE = 24;
  localparam logic [31:0] OFFSET_INPUT = 32'h80020000;
  localparam logic [31:0] OFFSET_OUTPUT = 32'h80020004;
  localparam logic [31:0] OFFSET_DIRECTION = 32'h80020008;
  localparam logic [31:0] OFFSET_MASK = 32'h8002000C;
  localparam logic [31:0] OFFSET_POLARITY = 32'h80020010;
  localparam logic [31:0] OFFSET_EDGE = 32'h80020014;
  localparam logic [31:0] OFFSET_PULSE = 32'h80020018;
  localparam logic [31:0] OFFSET_COUNTER = 32'h8002001C;
  localparam logic [23:0] RESET_CHANNELS = 24'h000000;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [19:0] RESET_COUNT = 20'h00000;
  localparam logic [31:0] VENDOR_CODE = 32'h000000AA; // arbitrary value
  localparam logic [31:0] DEVICE_CODE = 32'h00000055; // arbitrary value
endpackage : gpio_pkg

// *** pulse_counter.sv ***
// shared pulse length down-counter
`timescale 1ns/100ps
`default_nettype none
module pulse_counter
  import gpio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [19:0] value_i,
  output logic [19:0] count_o,
  output logic active_o
);
  typedef struct packed {
    logic [19:0] count;
  } cnt_state_t;
  cnt_state_t state, next_state;

  always_comb begin
    next_state = state;
    if (load_i) begin
      next_state.count = value_i;
    end else if (state.count != RESET_COUNT) begin
      next_state.count = state.count - 20'h00001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.count <= RESET_COUNT;
    end else begin
      state <= next_state;
    end
  end

  assign count_o = state.count;
  assign active_o = (state.count != RESET_COUNT);

  a_count_holds_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.count == RESET_COUNT && !load_i) |=> state.count == RESET_COUNT)
    else $error("counter left zero without a load");
  a_count_steps_down: assert property (@(posedge clk_i) disable iff (rst_i)
    (state.count != RESET_COUNT && !load_i) |=> state.count == $past(state.count) - 20'h00001)
    else $error("counter did not decrement by one");
endmodule : pulse_counter
`default_nettype wire

// *** irq_detect.sv ***
// per-channel interrupt detector, level or edge, selectable polarity
`timescale 1ns/100ps
`default_nettype none
module irq_detect
  import gpio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] level_i,
  input wire logic [7:0] mask_i,
  input wire logic [7:0] polarity_i,
  input wire logic [7:0] edge_i,
  output logic [7:0] irq_o
);
  typedef struct packed {
    logic [7:0] prev;
    logic [7:0] irq;
  } det_state_t;
  det_state_t state, next_state;
  logic [7:0] active;

  always_comb begin
    next_state = state;
    next_state.prev = level_i;
    active = ~(level_i ^ polarity_i);
    for (int i = 0; i < IRQ_COUNT; i++) begin
      if (edge_i[i]) begin
        next_state.irq[i] = mask_i[i] & active[i] & (state.prev[i] != level_i[i]);
      end else begin
        next_state.irq[i] = mask_i[i] & active[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.prev <= RESET_BYTE;
      state.irq <= RESET_BYTE;
    end else begin
      state <= next_state;
    end
  end

  assign irq_o = state.irq;

  a_mask_blocks_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    !mask_i[0] |=> !irq_o[0])
    else $error("masked channel raised an interrupt");
  a_edge_is_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    (edge_i[0] && $stable(edge_i[0]) && $stable(level_i[0])) |=> !irq_o[0])
    else $error("edge mode fired without a change");
endmodule : irq_detect
`default_nettype wire

// *** gpio_pulse_command_port.sv ***
// 24-channel discrete port with shared pulse command counter and interrupts
`timescale 1ns/100ps
`default_nettype none
module gpio_pulse_command_port
  import gpio_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  input wire logic [23:0] pin_i,
  output logic [23:0] pin_o,
  output logic [23:0] pin_oe_o,
  output logic [31:0] irq_o
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [23:0] sync1;
    logic [23:0] sync2;
    logic [23:0] out_value;
    logic [23:0] direction;
    logic [7:0] mask;
    logic [7:0] polarity;
    logic [7:0] edge_sel;
    logic [7:0] pulse_en;
    logic [31:0] rdata;
    logic ready;
    logic [23:0] pin;
    logic [23:0] pin_oe;
    logic [31:0] irq;
  } port_state_t;
  port_state_t state, next_state;

  logic wr_access;
  logic rd_access;
  logic count_load;
  logic [19:0] count;
  logic count_active;
  logic [7:0] irq_lines;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic hit(input logic [31:0] addr, input logic [31:0] offset);
    hit = (addr == offset);
  endfunction : hit

  function automatic logic [31:0] upper_byte(input logic [7:0] value);
    upper_byte = {8'h00, value, 16'h0000};
  endfunction : upper_byte

  assign wr_access = psel_i & penable_i & pwrite_i;
  assign rd_access = psel_i & ~pwrite_i;
  assign count_load = wr_access & hit(paddr_i, OFFSET_COUNTER);

  // ****************************************************************
  // leaf blocks
  // ****************************************************************
  pulse_counter u_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(count_load),
    .value_i(pwdata_i[COUNT_WIDTH-1:0]),
    .count_o(count),
    .active_o(count_active)
  );

  irq_detect u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_i(state.sync2[23:16]),
    .mask_i(state.mask),
    .polarity_i(state.polarity),
    .edge_i(state.edge_sel),
    .irq_o(irq_lines)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [23:0] pulse_mask;
    logic [23:0] drive;
    pulse_mask = '0;
    drive = '0;
    next_state = state;
    next_state.sync1 = pin_i;
    next_state.sync2 = state.sync1;
    next_state.ready = psel_i & ~penable_i;
    next_state.rdata = state.rdata;

    if (wr_access) begin
      if (hit(paddr_i, OFFSET_OUTPUT)) begin
        next_state.out_value = pwdata_i[23:0];
      end else if (hit(paddr_i, OFFSET_DIRECTION)) begin
        next_state.direction = pwdata_i[23:0];
      end else if (hit(paddr_i, OFFSET_MASK)) begin
        next_state.mask = pwdata_i[23:16];
      end else if (hit(paddr_i, OFFSET_POLARITY)) begin
        next_state.polarity = pwdata_i[23:16];
      end else if (hit(paddr_i, OFFSET_EDGE)) begin
        next_state.edge_sel = pwdata_i[23:16];
      end else if (hit(paddr_i, OFFSET_PULSE)) begin
        next_state.pulse_en = pwdata_i[7:0];
      end
      // other addresses, including input, are ignored here; a counter write is decoded in count_load
    end

    if (rd_access) begin
      if (hit(paddr_i, OFFSET_INPUT)) begin
        next_state.rdata = {8'h00, state.sync2};
      end else if (hit(paddr_i, OFFSET_OUTPUT)) begin
        next_state.rdata = {8'h00, state.out_value};
      end else if (hit(paddr_i, OFFSET_DIRECTION)) begin
        next_state.rdata = {8'h00, state.direction};
      end else if (hit(paddr_i, OFFSET_MASK)) begin
        next_state.rdata = upper_byte(state.mask);
      end else if (hit(paddr_i, OFFSET_POLARITY)) begin
        next_state.rdata = upper_byte(state.polarity);
      end else if (hit(paddr_i, OFFSET_EDGE)) begin
        next_state.rdata = upper_byte(state.edge_sel);
      end else if (hit(paddr_i, OFFSET_PULSE)) begin
        next_state.rdata = {24'h000000, state.pulse_en};
      end else if (hit(paddr_i, OFFSET_COUNTER)) begin
        next_state.rdata = {12'h000, count};
      end else begin
        next_state.rdata = 32'h00000000;
      end
    end

    // pulse channels are gated by the shared counter on the next cycle
    pulse_mask[7:0] = next_state.pulse_en & next_state.direction[7:0];
    drive = next_state.out_value;
    for (int i = 0; i < PULSE_CHANNELS; i++) begin
      if (pulse_mask[i]) begin
        drive[i] = next_state.out_value[i] & next_active();
      end
    end
    next_state.pin = drive;
    next_state.pin_oe = next_state.direction;
    next_state.irq = {irq_lines, 24'h000000};
  end

  // counter value one cycle ahead, so the pin tracks the count exactly
  function automatic logic next_active();
    if (count_load) begin
      next_active = (pwdata_i[COUNT_WIDTH-1:0] != RESET_COUNT);
    end else begin
      next_active = (count > 20'h00001);
    end
  endfunction : next_active

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state.sync1 <= RESET_CHANNELS;
      state.sync2 <= RESET_CHANNELS;
      state.out_value <= RESET_CHANNELS;
      state.direction <= RESET_CHANNELS;
      state.mask <= RESET_BYTE;
      state.polarity <= RESET_BYTE;
      state.edge_sel <= RESET_BYTE;
      state.pulse_en <= RESET_BYTE;
      state.rdata <= 32'h00000000;
      state.ready <= 1'b0;
      state.pin <= RESET_CHANNELS;
      state.pin_oe <= RESET_CHANNELS;
      state.irq <= 32'h00000000;
    end else begin
      state <= next_state;
    end
  end

  assign prdata_o = state.rdata;
  assign pready_o = state.ready;
  assign pin_o = state.pin;
  assign pin_oe_o = state.pin_oe;
  assign irq_o = state.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic pulse_en_out0;
  assign pulse_en_out0 = state.pulse_en[0] & state.direction[0] & state.out_value[0];

  sequence pulse_start;
    count_load && pwdata_i[19:0] == 20'h00003 && pulse_en_out0;
  endsequence

  // any non-zero load while channel 0 is enabled, driven and has its output bit set
  sequence pulse_load_any;
    count_load && pwdata_i[19:0] != 20'h00000 && pulse_en_out0;
  endsequence

  a_pulse_width_3: assert property (@(posedge clk_i) disable iff (rst_i)
    pulse_start |=> pin_o[0] [*3] ##1 (!pin_o[0] || count_load || $changed(state.pulse_en)))
    else $error("pulse width not equal to loaded count");
  a_input_no_drive: assert property (@(posedge clk_i) disable iff (rst_i)
    !next_state.direction[0] |=> !pin_oe_o[0])
    else $error("input channel driven");
  a_pulse_needs_out: assert property (@(posedge clk_i) disable iff (rst_i)
    (!state.direction[1] && state.pulse_en[1]) |-> pin_o[1] == state.out_value[1])
    else $error("pulse on input channel");
  a_pulses_in_phase: assert property (@(posedge clk_i) disable iff (rst_i)
    (&(state.pulse_en[1:0] & state.direction[1:0] & state.out_value[1:0]) && $stable(state.out_value)
     && $stable(state.pulse_en)) |-> pin_o[0] == pin_o[1])
    else $error("pulse outputs out of phase");
  a_low_irq_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o[23:0] == 24'h000000)
    else $error("interrupt raised on a line without a channel");
  a_zero_no_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    (count_load && pwdata_i[19:0] == 20'h00000 && state.pulse_en[0] && state.direction[0]
     && $stable(state.pulse_en)) |=> !pin_o[0])
    else $error("zero count produced a pulse");
  a_pulse_rises: assert property (@(posedge clk_i) disable iff (rst_i)
    pulse_load_any |=> pin_o[0])
    else $error("pulse did not start after a counter load");
  a_pulse_ends_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (count == 20'h00000 && !wr_access && state.pulse_en[0] && state.direction[0]) |=> !pin_o[0])
    else $error("pulse output high with counter at zero");
  a_pulse_en_field: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_access && hit(paddr_i, OFFSET_PULSE)) |=> state.pulse_en == $past(pwdata_i[7:0]))
    else $error("pulse enable write not taken from bits 7..0");
  a_mask_field: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_access && hit(paddr_i, OFFSET_MASK)) |=> state.mask == $past(pwdata_i[23:16]))
    else $error("mask write not taken from bits 23..16");
  a_out_field: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_access && hit(paddr_i, OFFSET_OUTPUT)) |=> state.out_value == $past(pwdata_i[23:0]))
    else $error("output write not taken from bits 23..0");
  a_input_read_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_access && hit(paddr_i, OFFSET_INPUT))
    |=> state.out_value == $past(state.out_value) && state.direction == $past(state.direction))
    else $error("write to input register changed state");
  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_access && paddr_i[31:5] != 27'h4001000) |=> prdata_o == 32'h00000000)
    else $error("unmapped read returned non-zero data");
  a_count_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd_access && hit(paddr_i, OFFSET_COUNTER)) |=> prdata_o == {12'h000, $past(count)})
    else $error("counter read did not return the live count");
  a_oe_follows_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_oe_o == state.direction)
    else $error("output enable differs from direction");
  a_plain_out: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_o[8] == state.out_value[8])
    else $error("non-pulse channel does not follow its output bit");
  a_irq_map: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o[31:24] == $past(irq_lines))
    else $error("interrupt lines not mapped onto bits 31..24");
  a_reset_quiet: assert property (@(posedge clk_i)
    rst_i |=> pin_oe_o == 24'h000000 && pin_o == 24'h000000)
    else $error("pins not quiet after reset");
endmodule : gpio_pulse_command_port
`default_nettype wire

// *** gpio_pin_model.sv ***
// far-side model: discrete pin drivers and an edge-counting interrupt sink
`timescale 1ns/100ps
`default_nettype none
module gpio_pin_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_i,
  input wire logic [23:0] ext_i,
  input wire logic [23:0] drive_i,
  input wire logic [23:0] drive_en_i,
  input wire logic [7:0] irq_i,
  output logic [23:0] level_o,
  output logic [7:0][7:0] edge_cnt_o
);
  logic [7:0] prev;
  // a driven pin shows the port value, a floating pin the outside source
  assign level_o = (drive_en_i & drive_i) | (~drive_en_i & ext_i);
  // the interrupt sink only sees rising edges
  always_ff @(posedge clk_i) begin
    prev <= irq_i;
    for (int k = 0; k < 8; k++) begin
      if (rst_i || clear_i) begin
        edge_cnt_o[k] <= 8'h00;
      end else if (irq_i[k] && !prev[k]) begin
        edge_cnt_o[k] <= edge_cnt_o[k] + 8'h01;
      end
    end
  end
endmodule : gpio_pin_model
`default_nettype wire

// *** gpio_pulse_command_port_tb.sv ***
// self-checking bench for the pulse command port
`timescale 1ns/100ps
`default_nettype none
module gpio_pulse_command_port_tb;
  import gpio_pkg::*;
  logic clk, rst, psel, penable, pwrite, pready, clr;
  logic [31:0] paddr, pwdata, prdata, irq, seed, v[8];
  logic [23:0] ext, lvl, pin, oe;
  logic [7:0][7:0] ecnt;
  logic [31:0] exp_q[$], msk_q[$];
  int error_cnt, num_checks, cyc, c, same, hi[4];
  logic [31:0] regs[8] = '{OFFSET_INPUT, OFFSET_OUTPUT, OFFSET_DIRECTION, OFFSET_MASK,
    OFFSET_POLARITY, OFFSET_EDGE, OFFSET_PULSE, OFFSET_COUNTER};
  logic [31:0] imp[8] = '{32'h00FFFFFF, 32'h00FFFFFF, 32'h00FFFFFF, 32'h00FF0000,
    32'h00FF0000, 32'h00FF0000, 32'h000000FF, 32'h000FFFFF};
  logic [31:0] wv[5] = '{32'h00000000, 32'h00000001, 32'h00000007, 32'h000000FF, 32'hFFF00003};
  int wid[5] = '{0, 1, 7, 255, 3};
  int ehi[4] = '{1, 1, 0, 10};
  int eed[4] = '{1, 1, 0, 1};

  gpio_pulse_command_port dut (.clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pin_i(lvl), .pin_o(pin), .pin_oe_o(oe), .irq_o(irq));
  gpio_pin_model far (.clk_i(clk), .rst_i(rst), .clear_i(clr), .ext_i(ext), .drive_i(pin),
    .drive_en_i(oe), .irq_i(irq[31:24]), .level_o(lvl), .edge_cnt_o(ecnt));

  // ***************
  // checks and bus
  // ***************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    psel = 1'b1;
    pwrite = wr;
    paddr = a;
    pwdata = d;
    @(negedge clk);
    penable = 1'b1;
    while (pready !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    psel = 1'b0;
    penable = 1'b0;
  endtask : apb

  task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h00000000);
  endtask : rd

  // read data watcher takes the oldest note on each completed read
  always @(posedge clk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) chk_val("unexpected read", 32'h00000000, 32'hFFFFFFFF);
      else chk_val("prdata", exp_q.pop_front(), prdata & msk_q.pop_front());
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ***************
  // main sequence
  // ***************
  initial begin
    {rst, psel, penable, pwrite, clr} = 5'b10000;
    {paddr, pwdata, ext, seed} = {64'h0, 24'h000000, 32'h00000A25};
    repeat (4) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++) rd(regs[i], 32'h0, (i == 6) ? 32'h0 : imp[i]);
    rd(32'h80020020, 32'h0, 32'hFFFFFFFF);
    chk_val("oe after reset", 32'h0, {8'h00, oe});
    chk_val("pin after reset", 32'h0, {8'h00, pin});
    $display("test reset done");
    for (int i = 1; i < 7; i++) begin
      seed = xs(seed);
      v[i] = seed;
      apb(1'b1, regs[i], v[i]);
    end
    seed = xs(seed);
    ext = seed[23:0];
    apb(1'b1, 32'h80020020, 32'hFFFFFFFF);
    apb(1'b1, OFFSET_INPUT, ~seed);
    for (int i = 1; i < 7; i++) rd(regs[i], v[i], imp[i]);
    chk_val("oe", {8'h00, v[2][23:0]}, {8'h00, oe});
    v[7] = v[1] & v[2] & ~{24'h0, v[6][7:0]};
    chk_val("pin", v[7] & 32'h00FFFFFF, {8'h00, pin & oe});
    rd(OFFSET_INPUT, v[7] | ({8'h00, ext} & ~v[2]), 32'h00FFFFFF);
    $display("test registers done");
    apb(1'b1, OFFSET_DIRECTION, 32'h0000001F);
    apb(1'b1, OFFSET_OUTPUT, 32'h00000037);
    apb(1'b1, OFFSET_PULSE, 32'hFFFFFF2F);
    for (int j = 0; j < 5; j++) begin
      apb(1'b1, OFFSET_COUNTER, wv[j]);
      c = 0;
      same = 1;
      repeat (wid[j] + 6) begin
        if (pin[0] === 1'b1) c++;
        if (pin[2:0] !== {3{pin[0]}} || pin[4:3] !== 2'b10 || oe[5] !== 1'b0) same = 0;
        @(negedge clk);
      end
      chk_val("pulse width", wid[j], c);
      chk_val("pulse group", 32'h1, same);
      rd(OFFSET_COUNTER, 32'h0, 32'hFFFFFFFF);
    end
    $display("test pulse done");
    ext[19:16] = 4'h0;
    apb(1'b1, OFFSET_MASK, 32'h000B0000);
    apb(1'b1, OFFSET_POLARITY, 32'h000D0000);
    apb(1'b1, OFFSET_EDGE, 32'h00070000);
    repeat (6) @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    hi = '{0, 0, 0, 0};
    same = 1;
    for (int i = 0; i < 30; i++) begin
      @(negedge clk);
      ext[19:16] = (i < 10) ? 4'hF : 4'h0;
      for (int k = 0; k < 4; k++) hi[k] += int'(irq[24 + k] === 1'b1);
      if (irq[23:0] !== 24'h0 || irq[31:28] !== 4'h0) same = 0;
    end
    for (int k = 0; k < 4; k++) begin
      chk_val("irq high cycles", ehi[k], hi[k]);
      chk_val("irq edges", eed[k], {24'h0, ecnt[k]});
    end
    chk_val("irq unused lines", 32'h1, same);
    $display("test interrupts done");
    final_report();
  end
endmodule : gpio_pulse_command_port_tb
`default_nettype wire
